// ==== rbs_pkg.sv ====
// Constants shared by the residual balance supervision block.
//
// Behaviour
// R1: A voltage imbalance is declared while the magnitude of the phase voltage sum minus three times the zero-sequence voltage exceeds 10 V.
// With delta wiring the code compares the line voltage sum alone against 10 V, with no zero-sequence term.
// R2: The zero-sequence term comes from the direct residual input or from the phase voltage sum, as the residual source choice selects.
// R3: A voltage supervision alarm lights the front alarm indicator and records error code 42.
// R4: The voltage imbalance must persist for a detection time of 1.0 to 100.0 s in 0.1 s steps before its alarm rises.
// R5: Each supervision has its own enable, and with it off that supervision never raises its alarm.
// R6: A current supervision alarm lights the front alarm indicator and records error code 41.
// R7: The current imbalance must persist for its own detection time of 1.0 to 100.0 s in 0.1 s steps before its alarm rises.
// R8: Delta wiring treats the voltage inputs as line-to-line quantities and wye wiring as line-to-neutral quantities.
// R9: In two-phase mode only the AB and BC line voltages are input and the CA line voltage is derived from them.
// R10: Software selecting the computed residual source must also select wye wiring and three-phase input.
// R11: With wye wiring the two/three-phase setting has no effect on any calculation.
// R12: With wye wiring the line-to-line voltages are computed from the measured line-to-neutral voltages.
// R13: A current imbalance is declared while the magnitude of the phase current sum minus the measured residual current exceeds a settable threshold.
// R14: A detection timer restarts from zero whenever its imbalance clears before the detection time has elapsed.
package rbs_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 20_000_000;
   localparam int STEP_MS      = 100;
   localparam int TICK_CYCLES  = CLK_HZ / 1000 * STEP_MS;
   localparam int DLY_W        = 10;
   localparam logic [9:0] DLY_MIN = 10'h00a;
   localparam logic [9:0] DLY_MAX = 10'h3e8;
   localparam logic [9:0] DLY_RST = 10'h00a;

   // -----------------------------------------------------------------
   // Thresholds and record codes
   // -----------------------------------------------------------------
   localparam int VOLT_LIMIT_MV = 10000;
   localparam int VOLT_LSB_MV   = 100;
   localparam int VOLT_LIMIT_CNT = VOLT_LIMIT_MV / VOLT_LSB_MV;
   localparam logic [15:0] CUR_LIMIT_RST = 16'h0064;
   localparam logic [7:0]  CODE_VOLT     = 8'h2a;
   localparam logic [7:0]  CODE_CURR     = 8'h29;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_VDLY  = 8'h04;
   localparam logic [7:0] ADDR_CDLY  = 8'h08;
   localparam logic [7:0] ADDR_CLIM  = 8'h0c;
   localparam logic [7:0] ADDR_STAT  = 8'h10;
   localparam logic [7:0] ADDR_MASK  = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   localparam logic [7:0] ADDR_LAB   = 8'h1c;
   localparam logic [7:0] ADDR_LBC   = 8'h20;
   localparam logic [7:0] ADDR_LCA   = 8'h24;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int CTRL_W       = 5;
   localparam int CTRL_VEN     = 0;
   localparam int CTRL_CEN     = 1;
   localparam int CTRL_SRC     = 2;
   localparam int CTRL_WYE     = 3;
   localparam int CTRL_TWO     = 4;
   localparam logic [4:0] CTRL_RST = 5'h08;
   localparam int EVT_VOLT     = 0;
   localparam int EVT_CURR     = 1;
   localparam int STATE_CODE   = 8;
endpackage : rbs_pkg

// ==== rbs_timer_if.sv ====
// Connection between the supervision core and one detection timer.
`timescale 1ns/1ns
interface rbs_timer_if;
   logic                     enable;
   logic                     cond;
   logic [rbs_pkg::DLY_W-1:0] delay;
   logic                     fire;

   modport core  (output enable, output cond, output delay, input fire);
   modport timer (input enable, input cond, input delay, output fire);
endinterface : rbs_timer_if

// ==== rbs_delay_timer.sv ====
// Detection timer: raises fire once its condition has held for the set time.
`timescale 1ns/1ns
module rbs_delay_timer #(
   parameter int TICK_CYCLES = rbs_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic  mclk_i,
   input  wire logic  rst_i,
   // Core side.
   rbs_timer_if.timer tmr
);
   localparam int PW = $clog2(TICK_CYCLES + 1);

   initial begin
      if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least one");
   end

   logic [PW-1:0]             pre_ff;
   logic [rbs_pkg::DLY_W-1:0] step_ff;
   logic                      fire_ff;
   logic                      run;
   logic                      tick;

   // The prescaler restarts with the condition, so the time is exact.
   assign run  = tmr.enable & tmr.cond;
   assign tick = (pre_ff == PW'(TICK_CYCLES - 1));

   // Tenth-second prescaler, held at zero while idle.
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run || tick) begin
         pre_ff <= '0; // R14
      end else begin
         pre_ff <= pre_ff + PW'(1);
      end
   end

   // Step counter; any gap in the condition starts it over.
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run) begin
         step_ff <= '0; // R14
      end else if (tick && step_ff < tmr.delay) begin
         step_ff <= step_ff + rbs_pkg::DLY_W'(1);
      end
   end

   // Fire level, dropped as soon as the condition or the enable goes.
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run) begin
         fire_ff <= 1'b0; // R5
      end else if (tick && step_ff + rbs_pkg::DLY_W'(1) >= tmr.delay) begin
         fire_ff <= 1'b1; // R4 R7
      end
   end

   assign tmr.fire = fire_ff & run;
endmodule : rbs_delay_timer

// ==== rbs_supervisor.sv ====
// Residual voltage and current balance supervision with its register file.
`timescale 1ns/1ns
module rbs_supervisor #(
   parameter int SAMPLE_W    = 16,
   parameter int TICK_CYCLES = rbs_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   // Register port.
   input  wire logic [7:0]          addr_i,
   input  wire logic [31:0]         wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [31:0]         rdata_o,
   // Sampled measurements.
   input  wire logic                sample_valid_i,
   input  wire logic [SAMPLE_W-1:0] volt_a_i,
   input  wire logic [SAMPLE_W-1:0] volt_b_i,
   input  wire logic [SAMPLE_W-1:0] volt_c_i,
   input  wire logic [SAMPLE_W-1:0] direct_residual_input_i,
   input  wire logic [SAMPLE_W-1:0] curr_a_i,
   input  wire logic [SAMPLE_W-1:0] curr_b_i,
   input  wire logic [SAMPLE_W-1:0] curr_c_i,
   input  wire logic [SAMPLE_W-1:0] curr_residual_i,
   // Derived line voltages.
   output logic                     line_valid_o,
   output logic      [SAMPLE_W:0]   line_ab_o,
   output logic      [SAMPLE_W:0]   line_bc_o,
   output logic      [SAMPLE_W:0]   line_ca_o,
   // Alarm and record.
   output logic                     alarm_led_o,
   output logic                     rec_valid_o,
   output logic      [7:0]          rec_code_o,
   output logic                     irq_o
);
   localparam int S = SAMPLE_W;
   localparam int W = SAMPLE_W + 4;

   initial begin
      if (SAMPLE_W < 8 || SAMPLE_W > 27) $error("SAMPLE_W must be 8 to 27");
   end

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Sign-extends a sample to the working width.
   function automatic logic signed [W-1:0] wide(input logic [S-1:0] x);
      return W'($signed(x));
   endfunction : wide

   // Magnitude of a signed working value.
   function automatic logic [W-1:0] mag(input logic signed [W-1:0] x);
      return (x < 0) ? W'(-x) : W'(x);
   endfunction : mag

   // Keeps a written detection time inside 1.0 to 100.0 s.
   function automatic logic [9:0] clamp_dly(input logic [31:0] d);
      if (d < 32'(rbs_pkg::DLY_MIN)) return rbs_pkg::DLY_MIN;
      else if (d > 32'(rbs_pkg::DLY_MAX)) return rbs_pkg::DLY_MAX;
      else return d[9:0];
   endfunction : clamp_dly

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [rbs_pkg::CTRL_W-1:0] ctrl_ff;
   logic [9:0]                 vdly_ff;
   logic [9:0]                 cdly_ff;
   logic [15:0]                clim_ff;
   logic [1:0]                 stat_ff;
   logic [1:0]                 mask_ff;
   logic [31:0]                rdata_ff;
   logic [1:0]                 evt;
   logic [1:0]                 nxt_stat;

   logic volt_balance_enable;
   logic current_balance_enable;
   logic residual_source_choice;
   logic wye_wiring;
   logic voltage_phase_count_select;

   assign volt_balance_enable        = ctrl_ff[rbs_pkg::CTRL_VEN];
   assign current_balance_enable     = ctrl_ff[rbs_pkg::CTRL_CEN];
   assign residual_source_choice     = ctrl_ff[rbs_pkg::CTRL_SRC];
   assign wye_wiring                 = ctrl_ff[rbs_pkg::CTRL_WYE];
   assign voltage_phase_count_select = ctrl_ff[rbs_pkg::CTRL_TWO];

   // Analog input configuration and supervision settings.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_ff <= rbs_pkg::CTRL_RST;
         vdly_ff <= rbs_pkg::DLY_RST;
         cdly_ff <= rbs_pkg::DLY_RST;
         clim_ff <= rbs_pkg::CUR_LIMIT_RST;
         mask_ff <= 2'h0;
      end else if (wr_i) begin
         if (addr_i == rbs_pkg::ADDR_CTRL) begin
            ctrl_ff <= wdata_i[rbs_pkg::CTRL_W-1:0];
         end else if (addr_i == rbs_pkg::ADDR_VDLY) begin
            vdly_ff <= clamp_dly(wdata_i); // R4
         end else if (addr_i == rbs_pkg::ADDR_CDLY) begin
            cdly_ff <= clamp_dly(wdata_i); // R7
         end else if (addr_i == rbs_pkg::ADDR_CLIM) begin
            clim_ff <= wdata_i[15:0];
         end else if (addr_i == rbs_pkg::ADDR_MASK) begin
            mask_ff <= wdata_i[1:0];
         end
      end
   end

   // Sticky events: a new event wins over a write-one clear.
   always_comb begin
      nxt_stat = stat_ff;
      if (wr_i && addr_i == rbs_pkg::ADDR_STAT) begin
         nxt_stat = stat_ff & ~wdata_i[1:0];
      end
      nxt_stat = nxt_stat | evt;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stat_ff <= 2'h0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   assign irq_o = |(stat_ff & mask_ff);

   // ---------------------------------------------------------------
   // Measurement path
   // ---------------------------------------------------------------
   logic signed [W-1:0] ab;
   logic signed [W-1:0] bc;
   logic signed [W-1:0] ca;
   logic signed [W-1:0] vsum;
   logic signed [W-1:0] resid;
   logic signed [W-1:0] vdiff;
   logic signed [W-1:0] idiff;
   logic                volt_imb_ff;
   logic                curr_imb_ff;
   logic                line_valid_ff;
   logic [S:0]          lab_ff;
   logic [S:0]          lbc_ff;
   logic [S:0]          lca_ff;

   // Line voltages from the wiring and phase-count settings.
   always_comb begin
      if (wye_wiring) begin
         ab = wide(volt_a_i) - wide(volt_b_i); // R12 R11
         bc = wide(volt_b_i) - wide(volt_c_i);
         ca = wide(volt_c_i) - wide(volt_a_i);
      end else begin
         ab = wide(volt_a_i); // R8
         bc = wide(volt_b_i);
         if (voltage_phase_count_select) begin
            ca = -(wide(volt_a_i) + wide(volt_b_i)); // R9
         end else begin
            ca = wide(volt_c_i);
         end
      end
   end

   // Balance equations for the voltage and current circuits.
   always_comb begin
      if (wye_wiring) begin
         vsum = wide(volt_a_i) + wide(volt_b_i) + wide(volt_c_i); // R8
      end else begin
         vsum = ab + bc + ca;
      end
      if (residual_source_choice) begin
         resid = wide(volt_a_i) + wide(volt_b_i) + wide(volt_c_i); // R2 R10
      end else begin
         resid = wide(direct_residual_input_i) * W'(3); // R2
      end
      // Delta wiring has no neutral, so the line sum alone must vanish.
      vdiff = wye_wiring ? (vsum - resid) : vsum;
      idiff = wide(curr_a_i) + wide(curr_b_i) + wide(curr_c_i)
              - wide(curr_residual_i);
   end

   // Imbalance flags and line voltages, refreshed on each sample.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         volt_imb_ff <= 1'b0;
         curr_imb_ff <= 1'b0;
         lab_ff      <= '0;
         lbc_ff      <= '0;
         lca_ff      <= '0;
      end else if (sample_valid_i) begin
         volt_imb_ff <= mag(vdiff) > W'(rbs_pkg::VOLT_LIMIT_CNT); // R1
         curr_imb_ff <= mag(idiff) > W'(clim_ff); // R13
         lab_ff      <= ab[S:0];
         lbc_ff      <= bc[S:0];
         lca_ff      <= ca[S:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         line_valid_ff <= 1'b0;
      end else begin
         line_valid_ff <= sample_valid_i;
      end
   end

   assign line_valid_o = line_valid_ff;
   assign line_ab_o    = lab_ff;
   assign line_bc_o    = lbc_ff;
   assign line_ca_o    = lca_ff;

   // ---------------------------------------------------------------
   // Detection timers
   // ---------------------------------------------------------------
   rbs_timer_if vtmr ();
   rbs_timer_if ctmr ();

   assign vtmr.enable = volt_balance_enable; // R5
   assign vtmr.cond   = volt_imb_ff;
   assign vtmr.delay  = vdly_ff;
   assign ctmr.enable = current_balance_enable; // R5
   assign ctmr.cond   = curr_imb_ff;
   assign ctmr.delay  = cdly_ff;

   rbs_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_volt_timer (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .tmr    (vtmr)
   );

   rbs_delay_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_curr_timer (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .tmr    (ctmr)
   );

   // ---------------------------------------------------------------
   // Alarm indicator and error record
   // ---------------------------------------------------------------
   logic       vfire_d_ff;
   logic       cfire_d_ff;
   logic [1:0] pend_ff;
   logic       rec_valid_ff;
   logic [7:0] rec_code_ff;
   logic       led_ff;
   logic [7:0] last_code_ff;

   assign evt[rbs_pkg::EVT_VOLT] = vtmr.fire & ~vfire_d_ff;
   assign evt[rbs_pkg::EVT_CURR] = ctmr.fire & ~cfire_d_ff;

   // Edge history of both alarms.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         vfire_d_ff <= 1'b0;
         cfire_d_ff <= 1'b0;
      end else begin
         vfire_d_ff <= vtmr.fire;
         cfire_d_ff <= ctmr.fire;
      end
   end

   // Alarm indicator follows either live supervision alarm.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         led_ff <= 1'b0;
      end else begin
         led_ff <= vtmr.fire | ctmr.fire; // R3 R6
      end
   end

   assign alarm_led_o = led_ff;

   // One record per cycle; the voltage code goes first if both rise.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pend_ff      <= 2'h0;
         rec_valid_ff <= 1'b0;
         rec_code_ff  <= 8'h00;
         last_code_ff <= 8'h00;
      end else begin
         rec_valid_ff <= 1'b0;
         if ((pend_ff[rbs_pkg::EVT_VOLT] | evt[rbs_pkg::EVT_VOLT]) == 1'b1) begin
            rec_valid_ff <= 1'b1;
            rec_code_ff  <= rbs_pkg::CODE_VOLT; // R3
            last_code_ff <= rbs_pkg::CODE_VOLT;
            pend_ff      <= {pend_ff[rbs_pkg::EVT_CURR] | evt[rbs_pkg::EVT_CURR], 1'b0};
         end else if ((pend_ff[rbs_pkg::EVT_CURR] | evt[rbs_pkg::EVT_CURR]) == 1'b1) begin
            rec_valid_ff <= 1'b1;
            rec_code_ff  <= rbs_pkg::CODE_CURR; // R6
            last_code_ff <= rbs_pkg::CODE_CURR;
            pend_ff      <= 2'h0;
         end
      end
   end

   assign rec_valid_o = rec_valid_ff;
   assign rec_code_o  = rec_code_ff;

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Read data appear the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd_i) begin
         if (addr_i == rbs_pkg::ADDR_CTRL) begin
            rdata_ff <= 32'(ctrl_ff);
         end else if (addr_i == rbs_pkg::ADDR_VDLY) begin
            rdata_ff <= 32'(vdly_ff);
         end else if (addr_i == rbs_pkg::ADDR_CDLY) begin
            rdata_ff <= 32'(cdly_ff);
         end else if (addr_i == rbs_pkg::ADDR_CLIM) begin
            rdata_ff <= 32'(clim_ff);
         end else if (addr_i == rbs_pkg::ADDR_STAT) begin
            rdata_ff <= 32'(stat_ff);
         end else if (addr_i == rbs_pkg::ADDR_MASK) begin
            rdata_ff <= 32'(mask_ff);
         end else if (addr_i == rbs_pkg::ADDR_STATE) begin
            rdata_ff <= {16'h0000, last_code_ff, 4'h0, curr_imb_ff, volt_imb_ff,
                         ctmr.fire, vtmr.fire};
         end else if (addr_i == rbs_pkg::ADDR_LAB) begin
            rdata_ff <= 32'($signed(lab_ff));
         end else if (addr_i == rbs_pkg::ADDR_LBC) begin
            rdata_ff <= 32'($signed(lbc_ff));
         end else if (addr_i == rbs_pkg::ADDR_LCA) begin
            rdata_ff <= 32'($signed(lca_ff));
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign rdata_o = rdata_ff;
endmodule : rbs_supervisor

// ==== rbs_frontend_model.sv ====
// Model of the sampled measurement front end.
`timescale 1ns/1ns
module rbs_frontend_model (
   // Clock.
   input  wire logic        mclk_i,
   // Sample outputs.
   output logic             valid_o,
   output logic      [63:0] vs_o,
   output logic      [63:0] cs_o
);
   // Idle at zero.
   initial begin
      valid_o = 1'b0;
      vs_o    = 64'h0;
      cs_o    = 64'h0;
   end

   // One sample set for one cycle, then the inverse.
   task automatic send(input logic [63:0] v, c);
      @(posedge mclk_i);
      valid_o <= 1'b1;
      vs_o    <= v;
      cs_o    <= c;
      @(posedge mclk_i);
      valid_o <= 1'b0;
      vs_o    <= ~v;
      cs_o    <= ~c;
   endtask : send
endmodule : rbs_frontend_model

// ==== rbs_supervisor_chk.sv ====
// Assertions on the supervision ports.
`timescale 1ns/1ns
module rbs_supervisor_chk #(
   parameter int SAMPLE_W    = 16,
   parameter int TICK_CYCLES = 4
) (
   // Clock, reset and bus.
   input wire logic mclk_i, rst_i, wr_i, rd_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i, rdata_o,
   // Samples.
   input wire logic sample_valid_i,
   input wire logic [SAMPLE_W-1:0] volt_a_i, volt_b_i, volt_c_i, direct_residual_input_i,
   input wire logic [SAMPLE_W-1:0] curr_a_i, curr_b_i, curr_c_i, curr_residual_i,
   // Results.
   input wire logic line_valid_o, alarm_led_o, rec_valid_o, irq_o,
   input wire logic [SAMPLE_W:0] line_ab_o, line_bc_o, line_ca_o,
   input wire logic [7:0] rec_code_o
);
   localparam int MIN_CYC = 10 * TICK_CYCLES;
   logic [4:0]               ctrl_ff;
   logic [15:0]              cnt_ff;
   logic signed [SAMPLE_W:0] sa, sb, sc, ab_ff, ca_ff;

   // Signed phase samples.
   assign sa = {volt_a_i[SAMPLE_W-1], volt_a_i};
   assign sb = {volt_b_i[SAMPLE_W-1], volt_b_i};
   assign sc = {volt_c_i[SAMPLE_W-1], volt_c_i};

   // Control mirror and cycles since its last write.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_ff <= 5'h08;
         cnt_ff  <= 16'h0;
      end else if (wr_i && addr_i == 8'h00) begin
         ctrl_ff <= wdata_i[4:0];
         cnt_ff  <= 16'h0;
      end else begin
         cnt_ff <= cnt_ff + {15'h0, ~&cnt_ff};
      end
   end

   // Expected line voltages.
   always_ff @(posedge mclk_i) begin
      if (sample_valid_i) begin
         ab_ff <= ctrl_ff[3] ? sa - sb : sa;
         ca_ff <= ctrl_ff[3] ? sc - sa : (ctrl_ff[4] ? -(sa + sb) : sc);
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero");
   rd_ctrl_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == {27'h0, $past(ctrl_ff)})
      else $error("control read wrong");
   line_pulse_a: assert property (line_valid_o == $past(sample_valid_i))
      else $error("line valid not after sample");
   line_ab_a: assert property (line_valid_o |-> line_ab_o == ab_ff)
      else $error("line ab wrong");
   line_ca_a: assert property (line_valid_o |-> line_ca_o == ca_ff)
      else $error("line ca wrong");
   rec_code_a: assert property (rec_valid_o |-> rec_code_o inside {8'h2a, 8'h29})
      else $error("record code unknown");
   rec_led_a: assert property (rec_valid_o |-> alarm_led_o)
      else $error("record without alarm");
   led_delay_a: assert property ($rose(alarm_led_o) |-> cnt_ff >= MIN_CYC)
      else $error("alarm too early");
   led_off_a: assert property (wr_i && addr_i == 8'h00 && wdata_i[1:0] == 2'b00
      |=> ##1 !alarm_led_o)
      else $error("alarm with supervision off");

   cover property (rec_valid_o && rec_code_o == 8'h2a);
   cover property (rec_valid_o && rec_code_o == 8'h29);
   cover property (line_valid_o && ctrl_ff[4:3] == 2'b10);
endmodule : rbs_supervisor_chk

bind rbs_supervisor rbs_supervisor_chk #(.SAMPLE_W(SAMPLE_W), .TICK_CYCLES(TICK_CYCLES))
   rbs_supervisor_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sample_valid_i(sample_valid_i),
   .volt_a_i(volt_a_i), .volt_b_i(volt_b_i), .volt_c_i(volt_c_i),
   .direct_residual_input_i(direct_residual_input_i), .curr_a_i(curr_a_i),
   .curr_b_i(curr_b_i), .curr_c_i(curr_c_i), .curr_residual_i(curr_residual_i),
   .line_valid_o(line_valid_o), .alarm_led_o(alarm_led_o), .rec_valid_o(rec_valid_o),
   .irq_o(irq_o), .line_ab_o(line_ab_o), .line_bc_o(line_bc_o), .line_ca_o(line_ca_o),
   .rec_code_o(rec_code_o));

// ==== residual_balance_supervision_tb.sv ====
// Bench for the residual balance supervision block.
`timescale 1ns/1ns
module residual_balance_supervision_tb;
   localparam int TICK = 4;
   localparam int TDET = 10 * TICK;
   logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic        sv, line_valid_o, alarm_led_o, rec_valid_o, irq_o;
   logic [63:0] vs, cs;
   logic [16:0] line_ab_o, line_bc_o, line_ca_o;
   logic [7:0]  rec_code_o;
   logic [7:0]  recs[$];
   int          n_errors = 0, samples_checked = 0, cyc = 0;

   rbs_frontend_model rbs_frontend_model_inst (.mclk_i(mclk_i), .valid_o(sv), .vs_o(vs),
      .cs_o(cs));
   rbs_supervisor #(.TICK_CYCLES(TICK)) rbs_supervisor_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sample_valid_i(sv), .volt_a_i(vs[63:48]), .volt_b_i(vs[47:32]), .volt_c_i(vs[31:16]),
      .direct_residual_input_i(vs[15:0]), .curr_a_i(cs[63:48]), .curr_b_i(cs[47:32]),
      .curr_c_i(cs[31:16]), .curr_residual_i(cs[15:0]), .line_valid_o(line_valid_o),
      .line_ab_o(line_ab_o), .line_bc_o(line_bc_o), .line_ca_o(line_ca_o),
      .alarm_led_o(alarm_led_o), .rec_valid_o(rec_valid_o), .rec_code_o(rec_code_o),
      .irq_o(irq_o));

   // 50 ns clock.
   always #25 mclk_i = ~mclk_i;

   // Record log and timeout.
   always @(posedge mclk_i) begin
      if (rec_valid_o === 1'b1) begin
         recs.push_back(rec_code_o);
      end
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask : rd

   task automatic send(input logic [63:0] v, c);
      rbs_frontend_model_inst.send(v, c);
   endtask : send

   // No record for a detection time and more.
   task automatic no_rec();
      repeat (TDET + 8) @(posedge mclk_i);
      #1 chk(32'(recs.size()), 32'h0);
   endtask : no_rec

   // Record due just after the detection time.
   task automatic expect_rec(input logic [7:0] code);
      int k;
      repeat (TDET - 2) @(posedge mclk_i);
      #1 chk(32'(recs.size()), 32'h0);
      k = 0;
      while (recs.size() == 0 && k < 8) begin
         @(posedge mclk_i);
         #1 k++;
      end
      chk(32'((recs.size() > 0) ? recs.pop_front() : 8'h00), 32'(code));
   endtask : expect_rec

   // Expected line voltages.
   function automatic logic [50:0] lexp(input logic [4:0] k, input logic [47:0] v);
      logic [16:0] a, b, x;
      a = {v[47], v[47:32]};
      b = {v[31], v[31:16]};
      x = {v[15], v[15:0]};
      if (k[3]) return {a - b, b - x, x - a};
      return {a, b, k[4] ? -(a + b) : x};
   endfunction : lexp

   task automatic t_regs();
      rd(8'h00, 32'h08);
      rd(8'h04, 32'h0a);
      rd(8'h08, 32'h0a);
      rd(8'h0c, 32'h64);
      rd(8'h10, 32'h00);
      rd(8'h14, 32'h00);
      wr(8'h28, 32'hffffffff);
      rd(8'h28, 32'h00);
      rd(8'h00, 32'h08);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0a);
      wr(8'h08, 32'h7d0);
      rd(8'h08, 32'h3e8);
      wr(8'h08, 32'h0a);
   endtask : t_regs

   task automatic t_line(input logic [4:0] k, input logic [47:0] v);
      logic [50:0] e;
      e = lexp(k, v);
      wr(8'h00, 32'(k));
      send({v, 16'h0}, 64'h0);
      #1 chk(32'(line_valid_o), 32'h1);
      chk(32'(line_ab_o), 32'(e[50:34]));
      chk(32'(line_bc_o), 32'(e[33:17]));
      chk(32'(line_ca_o), 32'(e[16:0]));
      rd(8'h24, {{15{e[16]}}, e[16:0]});
   endtask : t_line

   task automatic t_volt();
      wr(8'h14, 32'h1);
      wr(8'h00, 32'h09);
      send({16'h0064, 48'h0}, 64'h0);
      no_rec();
      send({16'h012c, 32'h0, 16'h0064}, 64'h0);
      no_rec();
      send({16'h0065, 48'h0}, 64'h0);
      repeat (20) @(posedge mclk_i);
      send(64'h0, 64'h0);
      send({16'h0065, 48'h0}, 64'h0);
      expect_rec(8'h2a);
      chk({30'h0, alarm_led_o, irq_o}, 32'h3);
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h1);
      #1 chk(32'(irq_o), 32'h0);
      send(64'h0, 64'h0);
      wr(8'h00, 32'h0d);
      send({16'h01f4, 48'h0}, 64'h0);
      no_rec();
   endtask : t_volt

   task automatic t_curr();
      wr(8'h00, 32'h0a);
      send(64'h0, {16'h0064, 48'h0});
      no_rec();
      send(64'h0, {16'h0065, 48'h0});
      expect_rec(8'h29);
      wr(8'h00, 32'h08);
      send({16'h0200, 48'h0}, {16'h0200, 48'h0});
      no_rec();
      wr(8'h10, 32'h3);
   endtask : t_curr

   task automatic t_pair();
      wr(8'h00, 32'h0b);
      send({16'h0200, 48'h0}, {16'h0200, 48'h0});
      expect_rec(8'h2a);
      @(posedge mclk_i);
      #1 chk(32'((recs.size() > 0) ? recs.pop_front() : 8'h00), 32'h29);
      rd(8'h10, 32'h3);
      wr(8'h14, 32'h0);
      #1 chk(32'(irq_o), 32'h0);
      wr(8'h00, 32'h08);
      @(posedge mclk_i);
      #1 chk(32'(alarm_led_o), 32'h0);
   endtask : t_pair

   task automatic complete_run();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // Main sequence.
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs();
      t_line(5'h08, {16'h012c, 16'h0064, 16'hffce});
      t_line(5'h18, {16'h012c, 16'h0064, 16'hffce});
      t_line(5'h00, {16'h012c, 16'h0064, 16'hffce});
      t_line(5'h10, {16'h012c, 16'h0064, 16'h0309});
      t_volt();
      t_curr();
      t_pair();
      complete_run();
   end
endmodule : residual_balance_supervision_tb
